// ---- src/gtc_timer.sv ----
// Purpose: 16-bit gated timer/counter with prescaler and overflow interrupt
// Assumes: Single clock; pins pass four flip-flops before use
// Notes: Registers over classic Wishbone, one-cycle ack
//
// Behaviour
// [RULE_01] Three software-selected modes: prescaled timer, synchronous counter, asynchronous counter.
// [RULE_02] Timer mode advances count once per instruction cycle after prescaler.
// [RULE_03] Counter mode advances count on external clock rising edges after prescaler.
// [RULE_04] Counter mode clock is synchronised or unsynchronised, selected by software.
// [RULE_05] First counting rising edge must be preceded by a seen falling edge.
// [RULE_06] Gate input may gate the count clock in both modes.
// [RULE_07] Low-power crystal may clock counter when core uses internal oscillator.
// [RULE_08] Count increments to maximum then wraps to zero.
// [RULE_09] Wrap to zero sets overflow flag, bit 0 of flag register.
// [RULE_10] Interrupt only when overflow, peripheral and global enables all set.
// [RULE_11] Overflow flag stays set until software clears it.
// [RULE_12] Software should zero count and flag before enabling interrupt.
// [RULE_13] Prescaler divides by 1, 2, 4 or 8 from control bits 5:4.
// [RULE_14] Prescaler hidden; cleared by any write to either count byte.
// [RULE_15] Asynchronous mode keeps counting in sleep and wakes on overflow.
// [RULE_16] Control register bits 6:0 read/write reset zero; bit 7 reads zero.
// [RULE_17] Gate enable bit 6 passes counts only while gate input low.
// [RULE_18] Low byte wrap carries into high byte in same update.
`timescale 1ns/1ps
`include "gtc_defs.svh"

module gtc_timer #(
  parameter int unsigned INSTR_DIV = `GTC_INSTR_DIV
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic countClockPin,
  input wire logic lpOscClk,
  input wire logic gateInputN,
  input wire logic intOscNoClkout,
  input wire logic sleepReq,
  output logic irqOut,
  output logic wakeUp
);

  localparam int unsigned IW = (INSTR_DIV > 1) ? $clog2(INSTR_DIV) : 1;

  function automatic logic [2:0] presMax(input logic [1:0] sel);
    logic [2:0] m;
    m = 3'h0;
    unique case (sel)
      2'h0: m = 3'h0;
      2'h1: m = 3'h1;
      2'h2: m = 3'h3;
      2'h3: m = 3'h7;
    endcase
    return m;
  endfunction : presMax

  gtc_pkg::gtc_ctrl_t ctrlReg;
  gtc_pkg::gtc_mode_t mode;
  logic [15:0] countReg;
  logic [2:0] prescReg;
  logic [IW-1:0] instrReg;
  logic flagReg;
  logic pieReg;
  logic peieReg;
  logic gieReg;
  logic [2:0] syncA;
  logic [2:0] syncB;
  logic [2:0] syncC;
  logic [2:0] pinLevel;
  logic extPrev;
  logic armedReg;

  logic busReq;
  logic busWr;
  logic wrLo;
  logic wrHi;
  logic cntWr;
  logic clrWr;
  logic extLevel;
  logic extRise;
  logic extFall;
  logic instrTick;
  logic gateOpen;
  logic srcTick;
  logic countEn;
  logic incTick;
  logic overflow;
  logic counterMode;

  // Wishbone decode; ack drops the cycle after it is given
  assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign busWr = busReq && wb_we_i && wb_sel_i[0];
  assign wrLo = busWr && (wb_adr_i == `GTC_OFF_CNT_LO);
  assign wrHi = busWr && (wb_adr_i == `GTC_OFF_CNT_HI);
  assign cntWr = wrLo || wrHi;
  assign clrWr = busWr && (wb_adr_i == `GTC_OFF_FLAG_CLR) && wb_dat_i[`GTC_BIT_OVF];

  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else if (ce) begin
      wb_ack_o <= busReq;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wb_dat_o <= 32'h0;
    end else if (ce && busReq) begin
      unique case (wb_adr_i)
        // [RULE_16] Bit 7 reads zero
        `GTC_OFF_CTRL: wb_dat_o <= {24'h0, 1'b0, ctrlReg[6:0]};
        `GTC_OFF_CNT_LO: wb_dat_o <= {24'h0, countReg[7:0]};
        `GTC_OFF_CNT_HI: wb_dat_o <= {24'h0, countReg[15:8]};
        `GTC_OFF_FLAG: wb_dat_o <= {31'h0, flagReg};
        `GTC_OFF_PIE: wb_dat_o <= {31'h0, pieReg};
        `GTC_OFF_IRQCTL: wb_dat_o <= {24'h0, gieReg, peieReg, 6'h0};
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end

  // [RULE_16] Control register write
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrlReg <= `GTC_CTRL_RESET;
    end else if (ce && busWr && wb_adr_i == `GTC_OFF_CTRL) begin
      ctrlReg <= wb_dat_i[7:0] & `GTC_CTRL_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pieReg <= 1'b0;
      peieReg <= 1'b0;
      gieReg <= 1'b0;
    end else if (ce && busWr) begin
      if (wb_adr_i == `GTC_OFF_PIE) begin
        pieReg <= wb_dat_i[`GTC_BIT_OVF_EN];
      end
      if (wb_adr_i == `GTC_OFF_IRQCTL) begin
        peieReg <= wb_dat_i[`GTC_BIT_PERIPHERAL_IRQ_ENABLE];
        gieReg <= wb_dat_i[`GTC_BIT_GIE];
      end
    end
  end

  // Pins: bit 0 count clock, bit 1 crystal, bit 2 gate
  generate
    for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge clk) begin
        if (rst) begin
          syncA[i] <= 1'b0;
          syncB[i] <= 1'b0;
          syncC[i] <= 1'b0;
          pinLevel[i] <= (i == 2) ? 1'b1 : 1'b0;
        end else if (ce) begin
          syncA[i] <= (i == 0) ? countClockPin : ((i == 1) ? lpOscClk : gateInputN);
          syncB[i] <= syncA[i];
          syncC[i] <= syncB[i];
          // A change counts once two stages agree
          if (syncB[i] == syncC[i]) begin
            pinLevel[i] <= syncC[i];
          end
        end
      end
    end
  endgenerate

  // [RULE_07] Crystal source only while core runs from internal oscillator
  assign extLevel = (ctrlReg.lpOscEnable && intOscNoClkout) ? pinLevel[1] : pinLevel[0];
  // [RULE_03] Rising edge of count clock
  assign extRise = extLevel && !extPrev;
  assign extFall = !extLevel && extPrev;

  always_comb begin
    if (!ctrlReg.timerOn) begin
      mode = gtc_pkg::GTC_MODE_OFF;
    end else if (!ctrlReg.extClockSelect) begin
      mode = gtc_pkg::GTC_MODE_TIMER;
    end else if (ctrlReg.asyncSelect) begin
      mode = gtc_pkg::GTC_MODE_ASYNC;
    end else begin
      mode = gtc_pkg::GTC_MODE_SYNC;
    end
  end

  assign counterMode = (mode == gtc_pkg::GTC_MODE_SYNC) || (mode == gtc_pkg::GTC_MODE_ASYNC);

  always_ff @(posedge clk) begin
    if (rst) begin
      extPrev <= 1'b0;
    end else if (ce) begin
      extPrev <= extLevel;
    end
  end

  // [RULE_05] Arm only after a falling edge in counter mode
  always_ff @(posedge clk) begin
    if (rst) begin
      armedReg <= 1'b0;
    end else if (ce) begin
      if (!counterMode) begin
        armedReg <= 1'b0;
      end else if (extFall) begin
        armedReg <= 1'b1;
      end
    end
  end

  // [RULE_02] Instruction cycle divider
  always_ff @(posedge clk) begin
    if (rst) begin
      instrReg <= '0;
    end else if (ce) begin
      if (instrTick) begin
        instrReg <= '0;
      end else begin
        instrReg <= instrReg + IW'(1);
      end
    end
  end

  assign instrTick = (instrReg == IW'(INSTR_DIV - 1));

  // [RULE_17] Gate passes counts while gate pin is low
  assign gateOpen = !ctrlReg.gateEnable || !pinLevel[2];

  // [RULE_01] Mode selects the count source
  always_comb begin
    srcTick = 1'b0;
    unique case (mode)
      gtc_pkg::GTC_MODE_OFF: srcTick = 1'b0;
      gtc_pkg::GTC_MODE_TIMER: srcTick = instrTick && !sleepReq;
      // [RULE_04] Synchronous counter halts in sleep
      gtc_pkg::GTC_MODE_SYNC: srcTick = extRise && armedReg && !sleepReq;
      // [RULE_15] Asynchronous counter runs through sleep
      gtc_pkg::GTC_MODE_ASYNC: srcTick = extRise && armedReg;
    endcase
  end

  // [RULE_06] Gating applies in every mode
  assign countEn = srcTick && gateOpen;

  // [RULE_13] Prescaler divide
  assign incTick = countEn && (prescReg == presMax(ctrlReg.prescaleSelect)) && !cntWr;
  assign overflow = incTick && (countReg == `GTC_MAX_COUNT);

  // [RULE_14] Count byte write clears prescaler
  always_ff @(posedge clk) begin
    if (rst) begin
      prescReg <= 3'h0;
    end else if (ce) begin
      if (cntWr) begin
        prescReg <= 3'h0;
      end else if (countEn) begin
        prescReg <= incTick ? 3'h0 : prescReg + 3'h1;
      end
    end
  end

  // [RULE_08] Count and wrap; software write wins over increment
  always_ff @(posedge clk) begin
    if (rst) begin
      countReg <= 16'h0;
    end else if (ce) begin
      if (wrLo) begin
        countReg[7:0] <= wb_dat_i[7:0];
      end
      if (wrHi) begin
        countReg[15:8] <= wb_dat_i[7:0];
      end
      // [RULE_18] Full 16-bit add carries low into high
      if (incTick) begin
        countReg <= countReg + 16'h1;
      end
    end
  end

  // [RULE_09] Overflow sets flag; set beats clear
  // [RULE_11] Flag held until cleared
  always_ff @(posedge clk) begin
    if (rst) begin
      flagReg <= 1'b0;
    end else if (ce) begin
      if (overflow) begin
        flagReg <= 1'b1;
      end else if (clrWr) begin
        flagReg <= 1'b0;
      end
    end
  end

  // [RULE_10] All three enables needed
  always_ff @(posedge clk) begin
    if (rst) begin
      irqOut <= 1'b0;
    end else if (ce) begin
      irqOut <= flagReg && pieReg && peieReg && gieReg;
    end
  end

  // [RULE_15] Wake pulse on overflow during sleep
  always_ff @(posedge clk) begin
    if (rst) begin
      wakeUp <= 1'b0;
    end else if (ce) begin
      wakeUp <= overflow && sleepReq && (mode == gtc_pkg::GTC_MODE_ASYNC);
    end
  end

  sequence s_ovf;
    ce && overflow;
  endsequence

  sequence s_timer_step;
    ce && mode == gtc_pkg::GTC_MODE_TIMER && incTick;
  endsequence

  a_wrap_zero: assert property (@(posedge clk) disable iff (rst) // [RULE_08]
    s_ovf |=> countReg == 16'h0)
    else $error("count did not wrap to zero");

  a_flag_set: assert property (@(posedge clk) disable iff (rst) // [RULE_09]
    s_ovf |=> flagReg)
    else $error("overflow did not set flag");

  a_flag_hold: assert property (@(posedge clk) disable iff (rst) // [RULE_11]
    $fell(flagReg) |-> $past(clrWr && ce))
    else $error("flag cleared without software");

  a_irq_enables: assert property (@(posedge clk) disable iff (rst) // [RULE_10]
    irqOut |-> $past(flagReg && pieReg && peieReg && gieReg))
    else $error("interrupt without all enables");

  a_timer_step: assert property (@(posedge clk) disable iff (rst) // [RULE_02]
    s_timer_step ##0 !overflow |=> countReg == $past(countReg) + 16'h1)
    else $error("timer step missed");

  a_low_carry: assert property (@(posedge clk) disable iff (rst) // [RULE_18]
    ce && incTick && countReg[7:0] == 8'hff |=> countReg[15:8] == $past(countReg[15:8]) + 8'h1)
    else $error("carry into high byte lost");

  a_presc_clear: assert property (@(posedge clk) disable iff (rst) // [RULE_14]
    ce && cntWr |=> prescReg == 3'h0)
    else $error("prescaler not cleared by write");

  a_presc_ratio: assert property (@(posedge clk) disable iff (rst) // [RULE_13]
    ce && countEn && !cntWr && prescReg != presMax(ctrlReg.prescaleSelect) |=> $stable(countReg))
    else $error("count stepped before prescale ratio");

  a_fall_first: assert property (@(posedge clk) disable iff (rst) // [RULE_05]
    countEn && counterMode |-> armedReg && $past(counterMode))
    else $error("count before falling edge");

  a_gate_block: assert property (@(posedge clk) disable iff (rst) // [RULE_17]
    ctrlReg.gateEnable && pinLevel[2] |-> !countEn)
    else $error("count passed closed gate");

  a_ctrl_bit7: assert property (@(posedge clk) disable iff (rst) // [RULE_16]
    ce && busReq && !wb_we_i && wb_adr_i == `GTC_OFF_CTRL |=> wb_ack_o && !wb_dat_o[7])
    else $error("control bit 7 not zero");

  a_async_wake: assert property (@(posedge clk) disable iff (rst) // [RULE_15]
    s_ovf ##0 sleepReq && mode == gtc_pkg::GTC_MODE_ASYNC |=> wakeUp)
    else $error("no wake on async overflow");

  a_ack_pulse: assert property (@(posedge clk) disable iff (rst)
    wb_ack_o && ce |=> !wb_ack_o)
    else $error("ack longer than one cycle");

endmodule : gtc_timer

// ---- pkg/gtc_defs.svh ----
// Purpose: Offsets, field positions, reset values and counts of the gated timer
// Assumes: Wishbone slave with 32-bit data, one aligned word per register
// Notes: Definitions only
`ifndef GTC_DEFS_SVH
`define GTC_DEFS_SVH

`define GTC_OFF_CTRL 8'h00
`define GTC_OFF_CNT_LO 8'h04
`define GTC_OFF_CNT_HI 8'h08
`define GTC_OFF_FLAG 8'h0c
`define GTC_OFF_FLAG_CLR 8'h10
`define GTC_OFF_PIE 8'h14
`define GTC_OFF_IRQCTL 8'h18

`define GTC_CTRL_RESET 8'h00
`define GTC_CTRL_WMASK 8'h7f
`define GTC_BIT_OVF 0
`define GTC_BIT_OVF_EN 0
`define GTC_BIT_PERIPHERAL_IRQ_ENABLE 6
`define GTC_BIT_GIE 7

`define GTC_INSTR_DIV 4
`define GTC_MAX_COUNT 16'hffff

`endif

// ---- pkg/gtc_pkg.sv ----
// Purpose: Types shared by the gated timer
// Assumes: Field layout of timer_control as below
// Notes: Bit 7 of timer_control is unimplemented
package gtc_pkg;

  typedef struct packed {
    logic unused;
    logic gateEnable;
    logic [1:0] prescaleSelect;
    logic lpOscEnable;
    logic asyncSelect;
    logic extClockSelect;
    logic timerOn;
  } gtc_ctrl_t;

  typedef enum logic [3:0] {
    GTC_MODE_OFF = 4'b0001,
    GTC_MODE_TIMER = 4'b0010,
    GTC_MODE_SYNC = 4'b0100,
    GTC_MODE_ASYNC = 4'b1000
  } gtc_mode_t;

endpackage : gtc_pkg

// ---- bench/gtc_ext_source.sv ----
// Purpose: External count clock source, crystal and gate driver
// Assumes: Driven from the system clock edge, slow enough to be synchronised
// Notes: Pin idles high; every pulse starts low
`timescale 1ns/1ps

module gtc_ext_source (
  input wire logic clk,
  output logic countClockPin,
  output logic lpOscClk,
  output logic gateInputN
);
  initial begin
    countClockPin = 1'b1;
    lpOscClk = 1'b1;
    gateInputN = 1'b1;
  end

  // falling edge first
  // Low then high, each held past the three-flop synchroniser
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      countClockPin <= 1'b0;
      repeat (4) @(posedge clk);
      countClockPin <= 1'b1;
      repeat (3) @(posedge clk);
    end
  endtask : pulses

  task automatic xtalPulses(input int n);
    repeat (n) begin
      @(posedge clk);
      lpOscClk <= 1'b0;
      repeat (4) @(posedge clk);
      lpOscClk <= 1'b1;
      repeat (3) @(posedge clk);
    end
  endtask : xtalPulses

  task automatic gate(input logic levelN);
    @(posedge clk);
    gateInputN <= levelN;
  endtask : gate
endmodule : gtc_ext_source

// ---- bench/test_gated_16bit_timer_counter.sv ----
// Purpose: Self-checking bench of the gated timer
// Assumes: Default instruction divider; pins come from the source model
// Notes: Clock enable, byte select and crystal path are all exercised
`timescale 1ns/1ps
`include "gtc_defs.svh"
`define CHK(nm, ex, got) tests_run++; if ((got) !== (ex)) begin failures++; $display("Error %s exp %0h got %0h", nm, ex, got); end

module test_gated_16bit_timer_counter;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sleepReq = 1'b0;
  logic ce = 1'b1, internal_oscillator = 1'b0;
  logic [3:0] sel = 4'hf, selNext = 4'hf;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rdat, q;
  logic ack, irqOut, wakeUp, pin, xtal, gateN;
  logic [15:0] c;
  int failures = 0, tests_run = 0, cycles = 0, wakeCnt = 0;

  always #2.5 clk = ~clk;

  gtc_timer #(.INSTR_DIV(`GTC_INSTR_DIV)) uut (.clk(clk), .rst(rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .countClockPin(pin), .lpOscClk(xtal), .gateInputN(gateN), .intOscNoClkout(internal_oscillator),
    .sleepReq(sleepReq), .irqOut(irqOut), .wakeUp(wakeUp));
  gtc_ext_source src (.clk(clk), .countClockPin(pin), .lpOscClk(xtal), .gateInputN(gateN));

  always @(posedge clk) begin
    if (wakeUp === 1'b1) wakeCnt <= wakeCnt + 1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end

  // Holds the request until ack is seen at an edge; only the cycle ceiling ends a wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= selNext;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic setCount(input logic [15:0] v);
    wb(1, `GTC_OFF_CNT_LO, {24'h0, v[7:0]}, q);
    wb(1, `GTC_OFF_CNT_HI, {24'h0, v[15:8]}, q);
  endtask : setCount

  task automatic getCount();
    wb(0, `GTC_OFF_CNT_LO, 0, q);
    c[7:0] = q[7:0];
    wb(0, `GTC_OFF_CNT_HI, 0, q);
    c[15:8] = q[7:0];
  endtask : getCount

  task automatic t_reset();
    wb(0, `GTC_OFF_CTRL, 0, q);
    `CHK("ctrl reset", 32'h0, q)
    wb(1, `GTC_OFF_CTRL, 32'hff, q);
    wb(0, `GTC_OFF_CTRL, 0, q);
    `CHK("ctrl bit7", 32'h7f, q)
    selNext = 4'he;
    wb(1, `GTC_OFF_CTRL, 32'h00, q);
    selNext = 4'hf;
    wb(0, `GTC_OFF_CTRL, 0, q);
    `CHK("ctrl write without sel0", 32'h7f, q)
    wb(0, 8'h1c, 0, q);
    `CHK("unmapped", 32'h0, q)
    wb(1, `GTC_OFF_CTRL, 32'h0, q);
  endtask : t_reset

  task automatic t_prescale();
    for (int p = 0; p < 4; p++) begin
      wb(1, `GTC_OFF_CTRL, 32'h03 | (p << 4), q);
      setCount(16'h0000);
      src.pulses(8);
      repeat (8) @(posedge clk);
      getCount();
      `CHK("prescaled count", 16'h8 >> p, c)
    end
    setCount(16'h0000);
    src.pulses(4);
    repeat (4) @(posedge clk);
    wb(1, `GTC_OFF_CNT_LO, 32'h0, q);
    src.pulses(4);
    repeat (8) @(posedge clk);
    getCount();
    `CHK("prescaler cleared by write", 16'h0, c)
  endtask : t_prescale

  task automatic t_gate();
    wb(1, `GTC_OFF_CTRL, 32'h43, q);
    setCount(16'h0000);
    src.pulses(4);
    repeat (8) @(posedge clk);
    getCount();
    `CHK("gate closed", 16'h0, c)
    src.gate(1'b0);
    repeat (4) @(posedge clk);
    src.pulses(4);
    repeat (8) @(posedge clk);
    getCount();
    `CHK("gate open", 16'h4, c)
    src.gate(1'b1);
  endtask : t_gate

  task automatic t_overflow();
    wb(1, `GTC_OFF_CTRL, 32'h0, q);
    setCount(16'h0000);
    wb(1, `GTC_OFF_FLAG_CLR, 32'h1, q);
    wb(1, `GTC_OFF_PIE, 32'h1, q);
    wb(1, `GTC_OFF_IRQCTL, 32'hc0, q);
    setCount(16'hffff);
    sleepReq <= 1'b1;
    wb(1, `GTC_OFF_CTRL, 32'h07, q);
    src.pulses(1);
    repeat (8) @(posedge clk);
    getCount();
    `CHK("wrap", 16'h0, c)
    wb(0, `GTC_OFF_FLAG, 0, q);
    `CHK("flag", 32'h1, q)
    `CHK("irq", 1'b1, irqOut)
    `CHK("wake", 1, wakeCnt)
    wb(1, `GTC_OFF_IRQCTL, 32'h40, q);
    repeat (3) @(posedge clk);
    `CHK("irq masked", 1'b0, irqOut)
    wb(1, `GTC_OFF_IRQCTL, 32'hc0, q);
    repeat (3) @(posedge clk);
    `CHK("flag sticky", 1'b1, irqOut)
    wb(1, `GTC_OFF_FLAG_CLR, 32'h1, q);
    repeat (3) @(posedge clk);
    `CHK("irq cleared", 1'b0, irqOut)
    wb(0, `GTC_OFF_FLAG, 0, q);
    `CHK("flag cleared", 32'h0, q)
    sleepReq <= 1'b0;
  endtask : t_overflow

  task automatic t_carry();
    wb(1, `GTC_OFF_CTRL, 32'h03, q);
    setCount(16'h00ff);
    src.pulses(1);
    repeat (8) @(posedge clk);
    getCount();
    `CHK("carry", 16'h0100, c)
    wb(1, `GTC_OFF_CTRL, 32'h01, q);
    // 24 timer edges: whole instruction cycles whatever the divider phase
    repeat (21) @(posedge clk);
    wb(1, `GTC_OFF_CTRL, 32'h00, q);
    getCount();
    `CHK("timer steps", 16'h0100 + 16'(24 / `GTC_INSTR_DIV), c)
  endtask : t_carry

  // Only three enabled edges in timer mode; a free-running count would pass 1
  task automatic t_enable();
    setCount(16'h0000);
    wb(1, `GTC_OFF_CTRL, 32'h01, q);
    ce <= 1'b0;
    repeat (40) @(posedge clk);
    ce <= 1'b1;
    wb(1, `GTC_OFF_CTRL, 32'h00, q);
    getCount();
    `CHK("clock enable freeze", 1'b1, c <= 16'h0001)
  endtask : t_enable

  task automatic t_xtal();
    internal_oscillator <= 1'b1;
    wb(1, `GTC_OFF_CTRL, 32'h0b, q);
    setCount(16'h0000);
    src.pulses(2);
    src.xtalPulses(3);
    repeat (8) @(posedge clk);
    getCount();
    `CHK("crystal source", 16'h3, c)
    internal_oscillator <= 1'b0;
    src.xtalPulses(2);
    repeat (8) @(posedge clk);
    getCount();
    `CHK("crystal unused without internal osc", 16'h3, c)
    wb(1, `GTC_OFF_CTRL, 32'h00, q);
  endtask : t_xtal

  task automatic wrap_up();
    $display("Checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_prescale();
    t_gate();
    t_overflow();
    t_carry();
    t_enable();
    t_xtal();
    wrap_up();
  end
endmodule : test_gated_16bit_timer_counter
